// ===== verilog/usb_dma_split_bus_handshake.sv
// Split-bus DMA handshake of the first DMA FIFO port, with AXI4-Lite registers.
// Assumes all pin inputs are synchronous to aclk; pads resolve out/oe outside.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`include "usb_dma_split_regs.svh"

// How it works
// - Interrupt output, polarity set by control
// - Port pins: split bus or GPIO
// - Request output with programmable polarity
// - Grant input active at programmed level
// - Strobe low edge or grant onset clocks each transfer
// - Strobe mode one uses strobe edge
// - IN pipe: transfer-end is input
// - OUT pipe: transfer-end marks final word
// - Transfer-end polarity programmable both ways
// - Reset low returns registers and counters
module usb_dma_split_bus_handshake #(
    parameter int COUNT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq_out,
    input wire logic [7:0] split_port_pins_in,
    output logic [7:0] split_port_pins_out,
    output logic [7:0] split_port_pins_oe,
    output logic xfer_request_out,
    input wire logic xfer_grant_in,
    input wire logic split_strobe_n,
    input wire logic xfer_last_in,
    output logic xfer_last_out,
    output logic xfer_last_oe
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    usb_dma_split_pkg::ctrl_t ctrl;
    usb_dma_split_pkg::pad8_t gpio;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [COUNT_W-1:0] count;
    logic tx_full;
    logic rx_full;
    logic end_seen;
    logic strobe_prev;
    logic grant_prev;

    // ----------------------------------------
    // Bus handshake state
    // ----------------------------------------
    logic [11:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;

    logic [31:0] wmask;
    logic do_write;
    logic do_read;
    logic wr_ctrl;
    logic wr_gpio;
    logic wr_data;
    logic wr_count;
    logic wr_status;
    logic rd_data_hit;
    logic grant_act;
    logic xfer_edge;
    logic xfer_go;
    logic last_word;
    logic end_in_act;
    logic next_req;
    logic [31:0] next_rdata;
    logic next_rerr;

    // Byte-lane mask from the held write strobes
    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign wr_ctrl = do_write && (aw_addr == `OFS_CTRL);
    assign wr_gpio = do_write && (aw_addr == `OFS_GPIO);
    assign wr_data = do_write && (aw_addr == `OFS_DATA) && w_strb[0];
    assign wr_count = do_write && (aw_addr == `OFS_COUNT);
    assign wr_status = do_write && (aw_addr == `OFS_STATUS);
    assign rd_data_hit = do_read && (s_axi_araddr[11:0] == `OFS_DATA);

    // ----------------------------------------
    // Handshake decode
    // ----------------------------------------
    // Split mode and enable both gate the grant, so GPIO use never moves FIFO data
    assign grant_act = (xfer_grant_in == ctrl.grant_pol) && !ctrl.gpio_mode && ctrl.dma_en;
    // Strobe mode one uses the falling strobe; mode zero counts each grant onset
    assign xfer_edge = ctrl.strobe_mode_sel ? (strobe_prev && !split_strobe_n)
                                            : (grant_act && !grant_prev);
    assign xfer_go = xfer_edge && grant_act && (count != '0)
                     && (ctrl.dir_out ? tx_full : !rx_full);
    assign last_word = (count == COUNT_W'(1));
    assign end_in_act = !ctrl.dir_out && (xfer_last_in == ctrl.last_pol);
    assign next_req = !ctrl.gpio_mode && ctrl.dma_en && (count != '0)
                      && (ctrl.dir_out ? tx_full : !rx_full);

    // Read mux; unmapped words answer zero with an error
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rerr = 1'b0;
        unique case (s_axi_araddr[11:0])
            `OFS_CTRL: next_rdata = {24'h00_0000, ctrl};
            `OFS_GPIO: next_rdata = {8'h00, split_port_pins_in, gpio};
            `OFS_DATA: next_rdata = {24'h00_0000, rx_data};
            `OFS_COUNT: next_rdata = 32'(count);
            `OFS_STATUS: next_rdata = {29'h0000_0000, end_seen, tx_full, rx_full};
            default: next_rerr = 1'b1;
        endcase
    end

    // ----------------------------------------
    // AXI write channel
    // ----------------------------------------
    // Address and data are caught separately so either order works
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ctrl || wr_gpio || wr_data || wr_count || wr_status
                                || aw_addr == `OFS_DATA) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // AXI read channel
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !do_read;
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= `CTRL_RESET;
            gpio <= `GPIO_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl <= (ctrl & ~wmask[7:0]) | (w_data[7:0] & wmask[7:0]);
            end
            if (wr_gpio)
            begin
                gpio <= (gpio & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
            end
        end
    end

    // ----------------------------------------
    // Transfer data and word count
    // ----------------------------------------
    // A transfer-end input on an IN pipe ends the run by clearing the count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= `COUNT_RESET;
            tx_data <= 8'h00;
            rx_data <= 8'h00;
            tx_full <= 1'b0;
            rx_full <= 1'b0;
            strobe_prev <= 1'b1;
            grant_prev <= 1'b0;
        end
        else
        begin
            strobe_prev <= split_strobe_n;
            grant_prev <= grant_act;
            if (wr_count)
            begin
                count <= w_data[COUNT_W-1:0];
            end
            else if (xfer_go && end_in_act)
            begin
                count <= '0;
            end
            else if (xfer_go)
            begin
                count <= count - COUNT_W'(1);
            end
            if (wr_data)
            begin
                tx_data <= w_data[7:0];
                tx_full <= 1'b1;
            end
            else if (xfer_go && ctrl.dir_out)
            begin
                tx_full <= 1'b0;
            end
            // Hardware set beats a software read that empties the byte
            if (xfer_go && !ctrl.dir_out)
            begin
                rx_data <= split_port_pins_in;
                rx_full <= 1'b1;
            end
            else if (rd_data_hit)
            begin
                rx_full <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // End flag, write one to clear, set wins
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            end_seen <= 1'b0;
        end
        else if ((xfer_go && (end_in_act || (ctrl.dir_out && last_word))))
        begin
            end_seen <= 1'b1;
        end
        else if (wr_status && w_strb[0] && w_data[`STAT_END_SEEN])
        begin
            end_seen <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pin outputs, all registered
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_out <= 1'b0;
            xfer_request_out <= 1'b0;
            split_port_pins_out <= 8'h00;
            split_port_pins_oe <= 8'h00;
            xfer_last_out <= 1'b0;
            xfer_last_oe <= 1'b0;
        end
        else
        begin
            irq_out <= ctrl.int_pol ? end_seen : !end_seen;
            xfer_request_out <= ctrl.req_pol ? next_req : !next_req;
            if (ctrl.gpio_mode)
            begin
                split_port_pins_out <= gpio.out;
                split_port_pins_oe <= gpio.oe;
            end
            else
            begin
                // Drive only while granted on an OUT pipe to avoid bus contention
                split_port_pins_out <= tx_data;
                split_port_pins_oe <= {8{grant_act && ctrl.dir_out}};
            end
            // Final-word marker; idle level is the inactive one
            xfer_last_out <= (grant_act && last_word) ? ctrl.last_pol : !ctrl.last_pol;
            xfer_last_oe <= ctrl.dir_out && !ctrl.gpio_mode;
        end
    end

endmodule : usb_dma_split_bus_handshake

// ===== verilog/usb_dma_split_regs.svh
// Register offsets, field positions, reset values for the split-bus DMA port.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef USB_DMA_SPLIT_REGS_SVH
`define USB_DMA_SPLIT_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_GPIO 12'h004
`define OFS_DATA 12'h008
`define OFS_COUNT 12'h00C
`define OFS_STATUS 12'h010

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_INT_POL 0
`define CTRL_GPIO_MODE 1
`define CTRL_REQ_POL 2
`define CTRL_GRANT_POL 3
`define CTRL_STB_MODE 4
`define CTRL_LAST_POL 5
`define CTRL_DIR_OUT 6
`define CTRL_DMA_EN 7

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define STAT_RX_FULL 0
`define STAT_TX_FULL 1
`define STAT_END_SEEN 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET 8'h02
`define GPIO_RESET 16'h0000
`define COUNT_RESET 16'h0000

// ----------------------------------------
// AXI response codes
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== verilog/usb_dma_split_pkg.sv
// Types shared by the split-bus DMA port.
// Assumes the field order matches the control register bit positions.
package usb_dma_split_pkg;

    // ----------------------------------------
    // Control word, bit 0 at the bottom
    // ----------------------------------------
    typedef struct packed {
        logic dma_en;
        logic dir_out;
        logic last_pol;
        logic strobe_mode_sel;
        logic grant_pol;
        logic req_pol;
        logic gpio_mode;
        logic int_pol;
    } ctrl_t;

    // ----------------------------------------
    // Pin group for a three-signal pad
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pad8_t;

endpackage : usb_dma_split_pkg

// ===== tb/usb_dma_split_bus_handshake_asserts.sv
// Checker of the split-bus DMA port, seeing only its pins.
// Assumes CTRL is written with all byte lanes enabled.
module dma_split_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic irq_out,
    input wire logic [7:0] split_port_pins_oe,
    input wire logic xfer_request_out,
    input wire logic xfer_grant_in,
    input wire logic xfer_last_out,
    input wire logic xfer_last_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    usb_dma_split_pkg::ctrl_t c;
    logic [1:0] age;
    logic [11:0] wa, ra;
    logic [7:0] wd;
    logic st, gr;
    assign st = age == 2'h3;
    assign gr = xfer_grant_in == c.grant_pol;
    // Shadow CTRL; any write restarts age since the design may commit early
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            c <= 8'h02;
        else if (s_axi_bvalid && s_axi_bready && wa[11:2] == 10'h000)
            c <= wd;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn || s_axi_wvalid && s_axi_wready || s_axi_bvalid)
            age <= 2'h0;
        else if (!st)
            age <= age + 2'h1;
    end
    // Addresses and data of the accesses in flight
    always_ff @(posedge aclk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            wa <= s_axi_awaddr[11:0];
        if (s_axi_wvalid && s_axi_wready)
            wd <= s_axi_wdata[7:0];
        if (s_axi_arvalid && s_axi_arready)
            ra <= s_axi_araddr[11:0];
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_reset_pins: assert property (disable iff (1'b0)
        !aresetn |=> split_port_pins_oe == 8'h00 && !xfer_last_oe) else $error("drive kept in reset");
    chk_irq_level: assert property (s_axi_rvalid && ra == 12'h010 && st
        |-> irq_out == (s_axi_rdata[2] ~^ c.int_pol)) else $error("interrupt level wrong");
    chk_req_gpio: assert property (st && c.gpio_mode |-> xfer_request_out != c.req_pol)
        else $error("request in port mode");
    chk_gpio_last: assert property (st && c.gpio_mode |-> !xfer_last_oe)
        else $error("end pin driven in port mode");
    chk_last_dir: assert property (st && !c.gpio_mode |-> xfer_last_oe == c.dir_out)
        else $error("end pin drive wrong");
    chk_in_pins: assert property (st && !c.gpio_mode && !c.dir_out
        |-> split_port_pins_oe == 8'h00) else $error("pins driven on IN pipe");
    chk_last_idle: assert property (st && !c.gpio_mode && c.dir_out && !gr && !$past(gr)
        |-> xfer_last_out != c.last_pol) else $error("end active while idle");
    chk_grant_oe: assert property (st && !c.gpio_mode && c.dir_out && c.dma_en
        |=> split_port_pins_oe == {8{$past(gr)}}) else $error("pin drive not tied to grant");
endmodule : dma_split_chk

bind usb_dma_split_bus_handshake dma_split_chk i_chk (.*);

// ===== tb/dma_far_end.sv
// Far-end DMA controller: grant, one strobe, optional end mark.
// Assumes the bench sets levels before raising en.
module dma_far_end (
    input wire logic aclk,
    input wire logic en,
    input wire logic req_act,
    input wire logic grant_act,
    input wire logic last_act,
    input wire logic end_now,
    input wire logic [3:0] gap,
    input wire logic [7:0] data,
    input wire logic xfer_request_out,
    input wire logic xfer_last_out,
    input wire logic [7:0] split_port_pins_out,
    input wire logic [7:0] split_port_pins_oe,
    output logic xfer_grant_in,
    output logic split_strobe_n,
    output logic xfer_last_in,
    output logic [7:0] split_port_pins_in,
    output logic [7:0] got,
    output logic got_last,
    output int xfers
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hs = 1'b0;
    // Pull-ups lift every pin that nobody drives
    assign split_port_pins_in = (split_port_pins_out & split_port_pins_oe)
        | ((hs ? data : 8'hff) & ~split_port_pins_oe);
    assign xfer_grant_in = hs ~^ grant_act;
    assign xfer_last_in = (hs && end_now) ~^ last_act;
    // One handshake per request seen, after an optional stall
    initial
    begin
        xfers = 0;
        split_strobe_n = 1'b1;
        forever
        begin
            @(posedge aclk);
            if (en && xfer_request_out === req_act)
            begin
                repeat (gap) @(posedge aclk);
                hs <= 1'b1;
                @(posedge aclk);
                split_strobe_n <= 1'b0;
                @(posedge aclk);
                split_strobe_n <= 1'b1;
                got <= split_port_pins_in;
                got_last <= xfer_last_out === last_act;
                @(posedge aclk);
                hs <= 1'b0;
                xfers <= xfers + 1;
                repeat (3) @(posedge aclk);
            end
        end
    end
endmodule : dma_far_end

// ===== tb/usb_dma_split_bus_handshake_test.sv
// Self-checking bench of the split-bus DMA port.
// Assumes the far-end model and the bound checker are compiled first.
`include "usb_dma_split_regs.svh"
module usb_dma_split_bus_handshake_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
    logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata, rv, seed = 32'h69a2_c5da;
    logic [3:0] s_axi_wstrb = 4'hf, gap = 4'h0, pol;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out;
    logic xfer_request_out, xfer_grant_in, split_strobe_n, xfer_last_in, xfer_last_out;
    logic xfer_last_oe, got_last, en = 1'b0, req_act = 1'b0, grant_act = 1'b0;
    logic last_act = 1'b0, end_now = 1'b0, ta, tw;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0] split_port_pins_in, split_port_pins_out, split_port_pins_oe, got;
    logic [7:0] data = 8'h00;
    int xfers, failures = 0, cmp_count = 0, n;
    usb_dma_split_bus_handshake i_dut (.*);
    dma_far_end i_far (.*);
    always #4 aclk = ~aclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Control word: DMA on, split bus, given direction, strobe mode and levels
    function automatic logic [31:0] ctl(input logic dir, input logic [3:0] p, input logic m);
        return {24'h00_0000, 1'b1, dir, p[3], m, p[2:1], 1'b0, p[0]};
    endfunction : ctl
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        {ta, tw} = 2'b00;
        s_axi_awaddr <= {20'h0_0000, a};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!(ta && tw))
        begin
            @(posedge aclk);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= {20'h0_0000, a};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    // Whole run needs about 500 cycles
    initial
    begin
        #80_000;
        failures++;
        conclude();
    end
    // Reset, port mode, refusal, then DMA passes in both directions
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_CTRL);
        check(rv, {24'h00_0000, `CTRL_RESET});
        check({irq_out, xfer_request_out}, 2'b11);
        check({xfer_last_oe, split_port_pins_oe}, 9'h000);
        for (int k = 0; k < 3; k++)
        begin
            seed = lfsr(seed);
            n = k == 0 ? 32'h0000_00ff : {16'h0000, seed[15:0]};
            wr(`OFS_GPIO, n);
            rd(`OFS_GPIO);
            // Output byte sits above the drive enables; undriven pins read high
            check(rv[23:0], {(n[15:8] & n[7:0]) | ~n[7:0], n[15:0]});
        end
        wr(`OFS_COUNT, 32'h0000_0001);
        wr(`OFS_CTRL, 32'h0000_0086);
        repeat (20) @(posedge aclk);
        rd(`OFS_COUNT);
        check(rv, 32'h0000_0001);
        check({31'h0000_0000, xfer_request_out}, 32'h0000_0000);
        wr(12'h020, seed);
        check(rsp, `RESP_SLVERR);
        rd(12'h020);
        check(rsp, `RESP_SLVERR);
        check(rv, 32'h0000_0000);
        $display("test port mode done");
        for (int k = 0; k < 6; k++)
        begin
            seed = lfsr(seed);
            pol = k < 2 ? {4{k[0]}} : seed[3:0];
            // Strobe-edge mode in the first four passes, grant-onset mode in the last two
            wr(`OFS_CTRL, ctl(k[0], pol, k < 4) & 32'h0000_007f);
            {req_act, grant_act, last_act, end_now} <= {pol[1], pol[2], pol[3], 1'b0};
            gap <= seed[7:4];
            wr(`OFS_COUNT, k[0] ? 32'h0000_0002 : 32'h0000_0003);
            en <= 1'b1;
            n = xfers;
            for (int t = 0; t < 2; t++)
            begin
                seed = lfsr(seed);
                data <= seed[7:0];
                end_now <= t[0];
                if (k[0])
                    wr(`OFS_DATA, {24'h00_0000, seed[7:0]});
                if (t == 0)
                    wr(`OFS_CTRL, ctl(k[0], pol, k < 4));
                while (xfers == n + t)
                    @(posedge aclk);
                if (k[0])
                    check({got, got_last}, {seed[7:0], t[0]});
                else
                    rd(`OFS_DATA);
                if (!k[0])
                    check(rv[7:0], seed[7:0]);
            end
            rd(`OFS_COUNT);
            check(rv, 32'h0000_0000);
            rd(`OFS_STATUS);
            check({irq_out, rv[2]}, {pol[0], 1'b1});
            wr(`OFS_STATUS, 32'h0000_0004);
            en <= 1'b0;
            rd(`OFS_STATUS);
            check({irq_out, rv[2:0]}, {!pol[0], 3'b000});
            $display("test pass %0d done", k);
        end
        // Mid-run reset must restore the control word and clear the count
        wr(`OFS_COUNT, 32'h0000_0005);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_CTRL);
        check(rv, {24'h00_0000, `CTRL_RESET});
        rd(`OFS_COUNT);
        check(rv, 32'h0000_0000);
        $display("test reset done");
        conclude();
    end
endmodule : usb_dma_split_bus_handshake_test
